/* common/ddrp_pkg.sv */
// How it works
// - DM high with write beat discards it
// - Per-rank ODT high enables, low disables termination
// - Termination covers DQ lanes, DQS, and DM or TDQS
// - Mode-register ODT disable makes ODT ignored
// - RAS/CAS/WE plus CS select the command
// - Reset low clears device regardless of CK
// - Read strobe edge-aligned; write strobe centred
// - x8 TDQS enable disables masking, terminates TDQS
// - x4 upper lanes and TDQS have no function
// - Data bus four bits x4, eight x8
// - Commands sampled on rising CK crossing
// - Rank with CS high ignores every command
// - Bank address picks mode register for op-code
package ddrp_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int RANKS = 2;            // Two ranks, one CS and ODT each
  localparam int DQW   = 8;            // Full data width (x8)
  localparam int BAW   = 3;            // Bank address width
  localparam int AW    = 15;           // Address width, A14..A0
  localparam int COLW  = 3;            // Column bits kept per rank
  localparam int DEPTH = 8;            // Words stored per rank
  localparam int MRN   = 4;            // Mode registers per rank
  // ------------------------------------------------------------
  // Mode-register fields and lane masks
  // ------------------------------------------------------------
  localparam logic [1:0] MR_TERM_IDX = 2'h1;   // Register with ODT/TDQS
  localparam int MR_TDQS_BIT = 11;             // TDQS enable
  localparam int MR_RTT_B0   = 2;              // Termination value bits,
  localparam int MR_RTT_B1   = 6;              // all zero means disabled
  localparam int MR_RTT_B2   = 9;
  localparam logic [DQW-1:0] LANES_X8 = 8'hff; // Lanes live on x8
  localparam logic [DQW-1:0] LANES_X4 = 8'h0f; // Lanes live on x4
  localparam logic [DQW-1:0] LANES_NONE = 8'h00;
  localparam logic [1:0] FIFO_FULL = 2'h2;     // Two-entry read buffer
  // ------------------------------------------------------------
  // Timing (bench link clock is far slower than clk)
  // ------------------------------------------------------------
  localparam int CLK_NS = 100;                 // Core clock period
  localparam int CK_NS  = 800;                 // Bench CK period
  localparam int CLK_PER_CK = CK_NS / CLK_NS;  // Samples per CK
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_ZQ  = 3'h6, CMD_NOP = 3'h7
  } ddrp_cmd_t;
  typedef enum logic {OST_IDLE = 1'b0, OST_DATA = 1'b1} ddrp_ost_t;
  typedef struct packed {
    logic [RANKS-1:0] cs_n;             // Rank selects, active low
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic [BAW-1:0]   ba;
    logic [AW-1:0]    addr;
  } ddrp_ca_t;
  typedef struct packed {
    logic [DQW-1:0] dq;                 // Data in
    logic           dqs;                // Write strobe in
    logic           dm;                 // Data mask in
  } ddrp_dqin_t;
  typedef struct packed {
    logic [DQW-1:0] dq;                 // Read data out
    logic [DQW-1:0] dq_oe;              // Per-lane drive enable
    logic           dqs;                // Read strobe out
    logic           dqs_oe;             // Strobe drive enable
  } ddrp_dqout_t;
  typedef struct packed {
    logic [RANKS-1:0] rank_on;          // Termination active per rank
    logic [DQW-1:0]   lanes;            // Terminated DQ lanes
    logic             strobe;           // DQS/DQS# terminated
    logic             dm;               // DM terminated
    logic             tdqs;             // TDQS/TDQS# terminated
  } ddrp_term_t;
  typedef struct packed {
    logic             ck;
    ddrp_ca_t         ca;
    logic [RANKS-1:0] odt;
    logic             reset_n;
    logic             x8;
    ddrp_dqin_t       dqi;
  } ddrp_pins_t;
  typedef struct packed {
    ddrp_pins_t                          s1;      // Sync stage one
    ddrp_pins_t                          s2;      // Sync stage two
    logic                                ck_prev;
    logic                                dqs_prev;
    logic [RANKS-1:0][MRN-1:0][AW-1:0]   mr;
    logic [RANKS-1:0][DEPTH-1:0][DQW-1:0] mem;
    logic                                wr_pend;
    logic                                wr_rank;
    logic [COLW-1:0]                     wr_col;
    logic                                rd_pend;
    logic [DQW-1:0]                      rd_word;
    logic [1:0][DQW-1:0]                 fifo;
    logic                                wp;
    logic                                rp;
    logic [1:0]                          cnt;
    ddrp_ost_t                           ost;
    ddrp_dqout_t                         dqo;
    ddrp_term_t                          term;
  } ddrp_state_t;
endpackage : ddrp_pkg

/* logic/ddrp_rank_pair.sv */
`timescale 1ns/1ps
module ddrp_rank_pair (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // Link clock and command pins
  input  wire logic                      ck,
  input  wire ddrp_pkg::ddrp_ca_t        ca,
  input  wire logic [ddrp_pkg::RANKS-1:0] odt,
  input  wire logic                      reset_n,
  input  wire logic                      x8_sel,
  // Data pins
  input  wire ddrp_pkg::ddrp_dqin_t      dqi,
  output      ddrp_pkg::ddrp_dqout_t     dqo,
  // Termination state
  output      ddrp_pkg::ddrp_term_t      term
);
  import ddrp_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic ddrp_cmd_t ddrp_decode(input ddrp_ca_t c);
    ddrp_decode = ddrp_cmd_t'({c.ras_n, c.cas_n, c.we_n});
  endfunction : ddrp_decode

  // All three value bits zero means termination switched off
  function automatic logic ddrp_odt_off(input logic [AW-1:0] m);
    ddrp_odt_off = ~(m[MR_RTT_B0] | m[MR_RTT_B1] | m[MR_RTT_B2]);
  endfunction : ddrp_odt_off

  // TDQS only exists on the x8 organisation
  function automatic logic ddrp_tdqs(input logic [AW-1:0] m,
                                     input logic x8);
    ddrp_tdqs = x8 & m[MR_TDQS_BIT];
  endfunction : ddrp_tdqs

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ddrp_state_t q;                       // Registered state
  ddrp_state_t n;                       // Next state
  ddrp_pins_t  pins_now;                // Raw pin bundle
  logic        ck_rise;                 // CK rising crossing seen
  logic        ck_fall;                 // CK falling crossing seen
  logic        dqs_rise;                // Write strobe rising edge
  logic        live;                    // Device out of reset
  logic        push;                    // Read word enters buffer
  logic        pop;                     // Read word leaves buffer

  assign pins_now = '{ck: ck, ca: ca, odt: odt, reset_n: reset_n,
                      x8: x8_sel, dqi: dqi};
  // Edges are taken only from the second sync stage
  assign ck_rise  = q.s2.ck & ~q.ck_prev;
  assign ck_fall  = ~q.s2.ck & q.ck_prev;
  assign dqs_rise = q.s2.dqi.dqs & ~q.dqs_prev;
  assign live     = q.s2.reset_n;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // One pass fills the whole next state; reset pin overrides last
  always_comb begin
    logic             any_on;
    logic             tdqs_on;
    logic             masked;
    logic [DQW-1:0]   word;
    ddrp_cmd_t        cmd;
    any_on  = 1'b0;
    tdqs_on = 1'b0;
    masked  = 1'b0;
    word    = '0;
    cmd     = ddrp_decode(q.s2.ca);
    push    = 1'b0;
    pop     = 1'b0;
    n          = q;
    n.s1       = pins_now;
    n.s2       = q.s1;
    n.ck_prev  = q.s2.ck;
    n.dqs_prev = q.s2.dqi.dqs;

    // Buffer fill: a pending read waits while both entries hold data
    if (q.rd_pend && (q.cnt != FIFO_FULL)) begin
      push            = 1'b1;
      n.fifo[q.wp]    = q.rd_word;
      n.wp            = ~q.wp;
      n.rd_pend       = 1'b0;
    end

    // Write beat captured at the centre of the bit by the strobe
    if (q.wr_pend && dqs_rise && !q.dqo.dqs_oe) begin
      masked = q.s2.dqi.dm &
               ~ddrp_tdqs(q.mr[q.wr_rank][MR_TERM_IDX], q.s2.x8);
      word   = q.mem[q.wr_rank][q.wr_col];
      if (q.s2.x8) begin
        word = q.s2.dqi.dq;
      end else begin
        word[3:0] = q.s2.dqi.dq[3:0];
      end
      if (!masked) begin
        n.mem[q.wr_rank][q.wr_col] = word;
      end
      n.wr_pend = 1'b0;
    end

    // Commands, taken per rank at the rising crossing
    if (ck_rise) begin
      for (int r = 0; r < RANKS; r++) begin
        if (!q.s2.ca.cs_n[r]) begin
          unique case (cmd)
            CMD_LMR: begin
              // Only four mode registers exist; BA2 high is ignored
              if (!q.s2.ca.ba[2]) begin
                n.mr[r][q.s2.ca.ba[1:0]] = q.s2.ca.addr;
              end
            end
            CMD_WR: begin
              n.wr_pend = 1'b1;
              n.wr_rank = r[0];
              n.wr_col  = q.s2.ca.addr[COLW-1:0];
            end
            CMD_RD: begin
              // A read behind a stalled one is dropped, not queued
              if (!q.rd_pend) begin
                n.rd_pend = 1'b1;
                n.rd_word = q.mem[r][q.s2.ca.addr[COLW-1:0]];
                if (!q.s2.x8) begin
                  n.rd_word[DQW-1:4] = 4'h0;
                end
              end
            end
            CMD_REF, CMD_PRE, CMD_ACT, CMD_ZQ, CMD_NOP: begin
              // No array timing is modelled for these
            end
          endcase
        end
      end

      // Termination follows each rank's own ODT pin
      for (int r = 0; r < RANKS; r++) begin
        n.term.rank_on[r] = q.s2.odt[r] &
            ~ddrp_odt_off(q.mr[r][MR_TERM_IDX]);
        any_on  = any_on | n.term.rank_on[r];
        tdqs_on = tdqs_on | (n.term.rank_on[r] &
                  ddrp_tdqs(q.mr[r][MR_TERM_IDX], q.s2.x8));
      end
      n.term.lanes  = any_on ? (q.s2.x8 ? LANES_X8 : LANES_X4)
                             : LANES_NONE;
      n.term.strobe = any_on;
      n.term.dm     = any_on & ~tdqs_on;
      n.term.tdqs   = tdqs_on;
    end

    // Read output: data and strobe change on the same CK crossing
    unique case (q.ost)
      OST_IDLE: begin
        if (ck_rise && (q.cnt != 2'h0)) begin
          pop          = 1'b1;
          n.dqo.dq     = q.fifo[q.rp];
          n.dqo.dq_oe  = q.s2.x8 ? LANES_X8 : LANES_X4;
          n.dqo.dqs    = 1'b1;
          n.dqo.dqs_oe = 1'b1;
          n.rp         = ~q.rp;
          n.ost        = OST_DATA;
        end
      end
      OST_DATA: begin
        if (ck_fall) begin
          n.dqo.dqs = 1'b0;
        end else if (ck_rise) begin
          if (q.cnt != 2'h0) begin
            pop         = 1'b1;
            n.dqo.dq    = q.fifo[q.rp];
            n.dqo.dqs   = 1'b1;
            n.rp        = ~q.rp;
          end else begin
            // Release the bus once the buffer has run dry
            n.dqo       = '0;
            n.ost       = OST_IDLE;
          end
        end
      end
    endcase
    n.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});

    // Reset pin works off clk alone, so a stopped CK cannot block it
    if (!live) begin
      n      = '0;
      n.s1   = pins_now;
      n.s2   = q.s1;
      n.ck_prev  = q.s2.ck;
      n.dqs_prev = q.s2.dqi.dqs;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign dqo  = q.dqo;
  assign term = q.term;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  mask_discard_a: assert property (@(posedge clk) disable iff (srst)
    (live && q.wr_pend && dqs_rise && !q.dqo.dqs_oe && q.s2.dqi.dm &&
     !ddrp_tdqs(q.mr[q.wr_rank][MR_TERM_IDX], q.s2.x8))
    |=> $stable(q.mem))
    else $error("masked write beat changed storage");

  odt_follow_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && q.s2.odt[0] &&
     !ddrp_odt_off(q.mr[0][MR_TERM_IDX])) |=> q.term.rank_on[0])
    else $error("rank 0 termination not enabled by odt");

  term_lanes_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && !q.s2.x8 && q.s2.odt[0] &&
     !ddrp_odt_off(q.mr[0][MR_TERM_IDX]))
    |=> (q.term.lanes == LANES_X4) && q.term.strobe)
    else $error("x4 termination lanes wrong");

  odt_ignore_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && ddrp_odt_off(q.mr[1][MR_TERM_IDX]))
    |=> !q.term.rank_on[1])
    else $error("rank 1 terminated while disabled");

  cs_ignore_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && (q.s2.ca.cs_n == 2'h3))
    |=> $stable(q.mr) && !$rose(q.wr_pend) && !$rose(q.rd_pend))
    else $error("command taken with no rank selected");

  mr_select_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && (q.s2.ca.cs_n == 2'h2) && !q.s2.ca.ba[2] &&
     (ddrp_decode(q.s2.ca) == CMD_LMR))
    |=> q.mr[0][$past(q.s2.ca.ba[1:0])] == $past(q.s2.ca.addr))
    else $error("mode register load misdirected");

  reset_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !live |=> !q.dqo.dqs_oe && (q.dqo.dq_oe == LANES_NONE) &&
              (q.term.rank_on == 2'h0) && !q.wr_pend)
    else $error("outputs active during reset");

  tdqs_write_a: assert property (@(posedge clk) disable iff (srst)
    (live && q.s2.x8 && q.wr_pend && dqs_rise && !q.dqo.dqs_oe &&
     q.mr[q.wr_rank][MR_TERM_IDX][MR_TDQS_BIT])
    |=> q.mem[$past(q.wr_rank)][$past(q.wr_col)] == $past(q.s2.dqi.dq))
    else $error("mask not disabled under tdqs");

  upper_dead_a: assert property (@(posedge clk) disable iff (srst)
    ($rose(q.dqo.dqs_oe) && !$past(q.s2.x8))
    |-> (q.dqo.dq_oe[7:4] == 4'h0) && (q.dqo.dq[7:4] == 4'h0))
    else $error("x4 drove upper lanes");

  edge_align_a: assert property (@(posedge clk) disable iff (srst)
    ($past(ck_rise) && q.dqo.dqs_oe && $past(q.dqo.dqs_oe) &&
     $past(q.cnt != 2'h0) && $past(q.ost == OST_DATA))
    |-> q.dqo.dqs && !$past(q.dqo.dqs))
    else $error("read data not edge aligned to strobe");

  ck_sample_a: assert property (@(posedge clk) disable iff (srst)
    $rose(q.wr_pend) |-> $past(ck_rise))
    else $error("command taken off the ck rising crossing");

  // Low ODT at a crossing switches rank 0 off, whatever the MR says
  odt_low_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && !q.s2.odt[0]) |=> !q.term.rank_on[0])
    else $error("rank 0 terminated with odt low");

  // Rank 0 follows its own pin only; rank 1 ODT has no say
  odt_own_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && !ddrp_odt_off(q.mr[0][MR_TERM_IDX]))
    |=> (q.term.rank_on[0] == $past(q.s2.odt[0])))
    else $error("rank 0 termination not set by its own odt");

  // Wide organisation terminates all eight lanes
  lanes_x8_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && q.s2.x8 && q.s2.odt[0] &&
     !ddrp_odt_off(q.mr[0][MR_TERM_IDX])) |=> (q.term.lanes == LANES_X8))
    else $error("x8 termination lanes wrong");

  // With TDQS on, the mask ball stops terminating and TDQS takes over
  tdqs_term_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && q.s2.odt[0] &&
     !ddrp_odt_off(q.mr[0][MR_TERM_IDX]) &&
     ddrp_tdqs(q.mr[0][MR_TERM_IDX], q.s2.x8))
    |=> q.term.tdqs && !q.term.dm)
    else $error("tdqs termination did not replace the mask ball");

  // A write code with rank 0 selected arms a beat for that column
  wr_take_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && (q.s2.ca.cs_n == 2'h2) &&
     (ddrp_decode(q.s2.ca) == CMD_WR))
    |=> q.wr_pend && !q.wr_rank &&
        (q.wr_col == $past(q.s2.ca.addr[COLW-1:0])))
    else $error("write command not decoded");

  // Narrow writes never touch the upper half of a stored word
  x4_upper_a: assert property (@(posedge clk) disable iff (srst)
    (live && !q.s2.x8 && q.wr_pend && dqs_rise && !q.dqo.dqs_oe)
    |=> (q.mem[$past(q.wr_rank)][$past(q.wr_col)][7:4] ==
         $past(q.mem[q.wr_rank][q.wr_col][7:4])))
    else $error("x4 write changed upper data bits");

  // Reads are taken only at the rising crossing as well
  rd_sample_a: assert property (@(posedge clk) disable iff (srst)
    $rose(q.rd_pend) |-> $past(ck_rise))
    else $error("read taken off the ck rising crossing");

  // A driven strobe drops only on the falling crossing of CK
  dqs_fall_a: assert property (@(posedge clk) disable iff (srst)
    ($fell(q.dqo.dqs) && q.dqo.dqs_oe) |-> $past(ck_fall))
    else $error("read strobe fell off the ck falling crossing");

  // A mode load aimed past the four registers leaves them all alone
  lmr_refuse_a: assert property (@(posedge clk) disable iff (srst)
    (ck_rise && live && q.s2.ca.ba[2] && (ddrp_decode(q.s2.ca) == CMD_LMR))
    |=> $stable(q.mr))
    else $error("mode load with high bank bit was taken");

  // Reset pin wipes mode registers and storage, not only the outputs
  reset_clear_a: assert property (@(posedge clk) disable iff (srst)
    !live |=> (q.mr == '0) && (q.mem == '0))
    else $error("state survived the reset pin");

endmodule : ddrp_rank_pair

/* tb/ddrp_ctrl_model.sv */
`timescale 1ns/1ps
module ddrp_ctrl_model (
  // Pacing clock
  input  wire logic                       clk,
  // Command pins toward the device
  output      logic                       ck,
  output      ddrp_pkg::ddrp_ca_t         ca,
  output      logic [ddrp_pkg::RANKS-1:0] odt,
  // Write data pins
  output      ddrp_pkg::ddrp_dqin_t       dqi
);
  import ddrp_pkg::*;
  // ----------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------
  // CK is parked low between frames, no rank selected
  initial begin
    ck  = 1'b0;
    ca  = '1;
    odt = '0;
    dqi = '0;
  end
  // Set up a command, then raise CK; pins hold until close_frame
  task automatic open_frame(input logic [1:0] cs_n, input ddrp_cmd_t cmd,
      input logic [2:0] ba, input logic [14:0] a, input logic [1:0] o);
    @(posedge clk);
    #1;
    ca.cs_n = cs_n;
    {ca.ras_n, ca.cas_n, ca.we_n} = cmd;
    ca.ba   = ba;
    ca.addr = a;
    odt     = o;
    repeat (2) @(posedge clk);
    #1 ck = 1'b1;
  endtask : open_frame
  // Lower CK, then release; released lines flip so stale values never pass
  task automatic close_frame();
    repeat (4) @(posedge clk);
    #1 ck = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ca.cs_n = 2'b11;
    ca.ba   = ~ca.ba;
    ca.addr = ~ca.addr;
  endtask : close_frame
  // One write beat, strobe raised in the middle of the bit
  task automatic beat(input logic [7:0] d, input logic m);
    @(posedge clk);
    #1;
    dqi.dq = d;
    dqi.dm = m;
    repeat (2) @(posedge clk);
    #1 dqi.dqs = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    dqi.dqs = 1'b0;
    dqi.dq  = ~d;
    dqi.dm  = ~m;
  endtask : beat
endmodule : ddrp_ctrl_model

/* tb/test_ddrp_rank_pair.sv */
`timescale 1ns/1ps
module test_ddrp_rank_pair;
  import ddrp_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic               clk;      // Core clock
  logic               srst;     // Core reset
  logic               reset_n;  // Device reset pin
  logic               x8_sel;   // Organisation strap
  logic               ck;       // Link clock from the model
  ddrp_ca_t           ca;       // Command pins
  logic [RANKS-1:0]   odt;      // Per-rank termination request
  ddrp_dqin_t         dqi;      // Write data pins
  ddrp_dqout_t        dqo;      // Read data pins
  ddrp_term_t         term;     // Termination state
  int                 errors;   // Mismatches seen
  int                 checks;   // Comparisons made
  // Clock at 10 MHz
  initial clk = 1'b0;
  always #50 clk = ~clk;
  ddrp_ctrl_model ctrl (.clk(clk), .ck(ck), .ca(ca), .odt(odt), .dqi(dqi));
  ddrp_rank_pair dut (.clk(clk), .srst(srst), .ck(ck), .ca(ca), .odt(odt),
    .reset_n(reset_n), .x8_sel(x8_sel), .dqi(dqi), .dqo(dqo), .term(term));
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // A frame that also checks what the read pins show while CK is high
  task automatic frame(input logic [1:0] cs_n, input ddrp_cmd_t cmd,
      input logic [14:0] a, input logic [1:0] o, input logic [7:0] ed,
      input logic [7:0] eoe);
    ctrl.open_frame(cs_n, cmd, 3'h0, a, o);
    repeat (4) @(posedge clk);
    check(dqo.dq, ed);
    check(dqo.dq_oe, eoe);
    check({dqo.dqs, dqo.dqs_oe}, {2{eoe != 8'h00}});
    ctrl.close_frame();
    repeat (2) @(posedge clk);
    check(dqo.dqs, 1'b0);
  endtask : frame
  task automatic wr(input logic [1:0] cs_n, input ddrp_cmd_t cmd,
      input logic [2:0] col, input logic [7:0] d, input logic m);
    ctrl.open_frame(cs_n, cmd, 3'h0, {12'h000, col}, 2'b00);
    ctrl.beat(d, m);
    ctrl.close_frame();
  endtask : wr
  task automatic lmr(input logic [1:0] cs_n, input logic [2:0] ba,
      input logic [14:0] a);
    ctrl.open_frame(cs_n, CMD_LMR, ba, a, 2'b00);
    ctrl.close_frame();
  endtask : lmr
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Masked beat, unselected rank, non-write command, back-to-back reads
  task automatic t_mask();
    wr(2'b10, CMD_WR, 3'h3, 8'ha5, 1'b0);
    wr(2'b10, CMD_WR, 3'h3, 8'h3c, 1'b1);
    wr(2'b01, CMD_WR, 3'h3, 8'h5a, 1'b0);
    wr(2'b11, CMD_WR, 3'h3, 8'h77, 1'b0);
    wr(2'b10, CMD_ACT, 3'h3, 8'h11, 1'b0);
    frame(2'b10, CMD_RD, 15'h3, 2'b00, 8'h00, 8'h00);
    frame(2'b01, CMD_RD, 15'h3, 2'b00, 8'ha5, 8'hff);
    frame(2'b11, CMD_NOP, 15'h3, 2'b00, 8'h5a, 8'hff);
    frame(2'b11, CMD_NOP, 15'h3, 2'b00, 8'h00, 8'h00);
    $display("t_mask done");
  endtask : t_mask
  // Termination per rank, mode-register gate, register selection
  task automatic t_term();
    frame(2'b11, CMD_NOP, 15'h0, 2'b11, 8'h00, 8'h00);
    check(term, 13'h0000);
    lmr(2'b10, 3'h0, 15'h0004);
    frame(2'b11, CMD_NOP, 15'h0, 2'b11, 8'h00, 8'h00);
    check(term, 13'h0000);
    lmr(2'b10, 3'h1, 15'h0004);
    frame(2'b11, CMD_NOP, 15'h0, 2'b11, 8'h00, 8'h00);
    check(term, {2'b01, 8'hff, 3'b110});
    // High bank bit: this load must not clobber the termination register
    lmr(2'b10, 3'h5, 15'h0000);
    frame(2'b11, CMD_NOP, 15'h0, 2'b10, 8'h00, 8'h00);
    check(term.rank_on, 2'b00);
    frame(2'b11, CMD_NOP, 15'h0, 2'b01, 8'h00, 8'h00);
    check(term.rank_on, 2'b01);
    $display("t_term done");
  endtask : t_term
  // Strobe termination on x8 takes over the mask ball
  task automatic t_tdqs();
    lmr(2'b10, 3'h1, 15'h0804);
    frame(2'b11, CMD_NOP, 15'h0, 2'b01, 8'h00, 8'h00);
    check(term, {2'b01, 8'hff, 3'b101});
    wr(2'b10, CMD_WR, 3'h5, 8'hc3, 1'b1);
    frame(2'b10, CMD_RD, 15'h5, 2'b01, 8'h00, 8'h00);
    frame(2'b11, CMD_NOP, 15'h0, 2'b01, 8'hc3, 8'hff);
    $display("t_tdqs done");
  endtask : t_tdqs
  // Narrow organisation: four lanes, upper balls idle, no TDQS term
  task automatic t_x4();
    #1 x8_sel = 1'b0;
    repeat (4) @(posedge clk);
    frame(2'b11, CMD_NOP, 15'h0, 2'b01, 8'h00, 8'h00);
    check(term, {2'b01, 8'h0f, 3'b110});
    wr(2'b10, CMD_WR, 3'h6, 8'h9e, 1'b0);
    frame(2'b10, CMD_RD, 15'h6, 2'b00, 8'h00, 8'h00);
    frame(2'b11, CMD_NOP, 15'h0, 2'b00, 8'h0e, 8'h0f);
    #1 x8_sel = 1'b1;
    repeat (4) @(posedge clk);
    $display("t_x4 done");
  endtask : t_x4
  // Device reset pin clears storage and mode registers with CK parked
  // Termination is raised first so that its clearing is visible
  task automatic t_reset();
    frame(2'b11, CMD_NOP, 15'h0, 2'b01, 8'h00, 8'h00);
    check(term, {2'b01, 8'hff, 3'b101});
    #1 reset_n = 1'b0;
    repeat (4) @(posedge clk);
    check(term, 13'h0000);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    frame(2'b11, CMD_NOP, 15'h0, 2'b11, 8'h00, 8'h00);
    check(term, 13'h0000);
    frame(2'b01, CMD_RD, 15'h3, 2'b00, 8'h00, 8'h00);
    frame(2'b11, CMD_NOP, 15'h0, 2'b00, 8'h00, 8'hff);
    $display("t_reset done");
  endtask : t_reset
  // ----------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    errors  = 0;
    checks  = 0;
    srst    = 1'b1;
    reset_n = 1'b1;
    x8_sel  = 1'b1;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    t_mask();
    t_term();
    t_tdqs();
    t_x4();
    t_reset();
    tally_and_finish();
  end
endmodule : test_ddrp_rank_pair
